// [dt_bus_master.sv]
// Purpose: Bus master model for the dual timer
// Assumes: Single word transfers only
// Notes: Released write data shows the inverse of the last word
`timescale 1ns/1ps

module dt_bus_master (
    input wire logic hclk, // Same clock as the counters
    input wire logic hready, // Slave ready
    input wire logic [31:0] hrdata, // Read data
    output logic hsel, // Select
    output logic [31:0] haddr, // Address
    output logic [1:0] htrans, // Transfer type
    output logic hwrite, // Direction
    output logic [2:0] hsize, // Word size
    output logic [31:0] hwdata // Write data
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // One transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        r = hrdata;
        hwdata <= ~d;
    endtask
endmodule // dt_bus_master

// [dt_pkg.sv]
// Purpose: Types for the dual timer
// Assumes: Nothing beyond the register header
// Notes: Bus slave states are one-hot
package dt_pkg;

    // Bus slave state: ready, or one wait cycle for a read
    typedef enum logic [1:0] {
        DT_ST_IDLE = 2'b01,
        DT_ST_RWAIT = 2'b10
    } dt_bus_state_t;

endpackage

// [dt_regs.svh]
// Purpose: Register offsets, field positions, reset values for the dual timer
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Counter 2 sits one block of 0x20 above counter 1
`ifndef DT_REGS_SVH
`define DT_REGS_SVH

// ----------------------------------------------------------------------
// Per-counter register offsets (word index in bits 4:2)
// ----------------------------------------------------------------------
`define DT_OFS_RELOAD 3'h0
`define DT_OFS_VALUE 3'h1
`define DT_OFS_CONTROL 3'h2
`define DT_OFS_IRQ_CLEAR 3'h3
`define DT_OFS_RAW_STATUS 3'h4
`define DT_OFS_MASKED_STATUS 3'h5
`define DT_OFS_BG_RELOAD 3'h6
`define DT_CH_STRIDE_BIT 5

// ----------------------------------------------------------------------
// Shared register byte addresses
// ----------------------------------------------------------------------
`define DT_ADDR_TEST_CONTROL 12'hF00
`define DT_ADDR_TEST_OUTPUT 12'hF04
`define DT_ADDR_PERIPH_ID3 12'hFEC

// ----------------------------------------------------------------------
// Control register fields and reset
// ----------------------------------------------------------------------
`define DT_CTRL_ENABLE 7
`define DT_CTRL_PERIODIC 6
`define DT_CTRL_IRQ_EN 5
`define DT_CTRL_PRE_HI 3
`define DT_CTRL_PRE_LO 2
`define DT_CTRL_SIZE32 1
`define DT_CTRL_ONESHOT 0
`define DT_CTRL_RESET 8'h20
`define DT_CTRL_WR_MASK 8'hEF

// ----------------------------------------------------------------------
// Prescale codes and counter constants
// ----------------------------------------------------------------------
`define DT_PRE_DIV1 2'h0
`define DT_PRE_DIV16 2'h1
`define DT_PRE_DIV256 2'h2
`define DT_MASK16 32'h0000FFFF
`define DT_MASK32 32'hFFFFFFFF
`define DT_RELOAD_RESET 32'h00000000
`define DT_VALUE_RESET 32'hFFFFFFFF

`endif

// [dt_timer.sv]
// Purpose: Dual down-counting timer with interrupts, reload and test mode
// Assumes: Counting clock is hclk; clock enables come from hclk logic
// Notes: Reads take one wait state, writes none; response always OKAY
//
// Notes on behaviour
// - Any write to clear register drops interrupt
// - Raw status bit 0 ignores enable
// - Masked status equals raw AND enable, drives pin
// - Background reload write keeps current count
// - Load and background reload share storage
// - Test control bit 0 selects test mode
// - Test output bits drive counter interrupts
// - Combined interrupt ORs test output bits
// - Counter 1 decrements only with its enable
// - Counter 2 decrements only with its enable
// - Counter raises interrupt on reaching zero
// - Combined interrupt is OR of both
// - Revision input shows in identification register
// - Interrupt enable resets to one
// - Load write replaces count at enabled edge
// - Load sets count at next enabled edge, background reloads later
// - Prescale divides by 1, 16, 256
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "dt_regs.svh"

module dt_timer (
    input wire logic hclk, // Bus and counting clock, 200 MHz
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response, always OKAY
    input wire logic counter1_clock_enable, // Counter 1 clock enable
    input wire logic counter2_clock_enable, // Counter 2 clock enable
    input wire logic [3:0] revision_tieoff_in, // Revision tie-off
    output logic counter1_irq_out, // Counter 1 interrupt
    output logic counter2_irq_out, // Counter 2 interrupt
    output logic combined_irq_out // Either interrupt
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    dt_pkg::dt_bus_state_t state_ff;
    dt_pkg::dt_bus_state_t nxt_state;
    logic [11:0] addr_ff;
    logic [11:0] nxt_addr;
    logic wr_ff;
    logic nxt_wr;
    logic hready_ff;
    logic nxt_hready;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_hrdata;
    logic hresp_ff;
    logic nxt_hresp;
    logic [31:0] rd_mux;
    logic accept;

    // Size is not decoded: whole-word transfers only
    // Address phase taken on a selected non-idle transfer
    assign accept = hsel && htrans[1] && hready;

    // Next state of the slave
    always_comb begin
        nxt_state = state_ff;
        nxt_addr = addr_ff;
        nxt_wr = 1'b0;
        nxt_hready = hready_ff;
        nxt_hrdata = hrdata_ff;
        nxt_hresp = 1'b0;
        case (state_ff)
            dt_pkg::DT_ST_IDLE: begin
                if (accept) begin
                    nxt_addr = haddr[11:0];
                    nxt_wr = hwrite;
                    if (!hwrite) begin
                        nxt_state = dt_pkg::DT_ST_RWAIT;
                        nxt_hready = 1'b0;
                    end
                end
            end
            dt_pkg::DT_ST_RWAIT: begin
                nxt_hrdata = rd_mux;
                nxt_hready = 1'b1;
                nxt_state = dt_pkg::DT_ST_IDLE;
            end
            default: begin
                nxt_state = dt_pkg::DT_ST_IDLE;
                nxt_hready = 1'b1;
            end
        endcase
    end

    // Slave registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= dt_pkg::DT_ST_IDLE;
            addr_ff <= 12'h000;
            wr_ff <= 1'b0;
            hready_ff <= 1'b1;
            hrdata_ff <= 32'h00000000;
            hresp_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
            wr_ff <= nxt_wr;
            hready_ff <= nxt_hready;
            hrdata_ff <= nxt_hrdata;
            hresp_ff <= nxt_hresp;
        end
    end

    // Bus outputs straight from the slave flip-flops
    assign hrdata = hrdata_ff;
    assign hreadyout = hready_ff;
    assign hresp = hresp_ff;

    // ------------------------------------------------------------------
    // Revision tie-off synchroniser and test registers
    // ------------------------------------------------------------------
    logic [3:0] rev_meta_ff;
    logic [3:0] rev_ff;
    logic test_mode_ff;
    logic nxt_test_mode;
    logic [1:0] test_out_ff;
    logic [1:0] nxt_test_out;
    logic wr_test_ctrl;
    logic wr_test_out;

    // Data-phase strobes for the shared test registers
    assign wr_test_ctrl = wr_ff && (addr_ff == `DT_ADDR_TEST_CONTROL);
    assign wr_test_out = wr_ff && (addr_ff == `DT_ADDR_TEST_OUTPUT);

    // Test control and test output written from data phase
    always_comb begin
        nxt_test_mode = test_mode_ff;
        nxt_test_out = test_out_ff;
        if (wr_test_ctrl) begin
            nxt_test_mode = hwdata[0];
        end
        if (wr_test_out) begin
            nxt_test_out = hwdata[1:0];
        end
    end

    // Test state and two-stage revision capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_mode_ff <= 1'b0;
            test_out_ff <= 2'b00;
            rev_meta_ff <= 4'h0;
            rev_ff <= 4'h0;
        end else begin
            test_mode_ff <= nxt_test_mode;
            test_out_ff <= nxt_test_out;
            rev_meta_ff <= revision_tieoff_in;
            rev_ff <= rev_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Two counters
    // ------------------------------------------------------------------
    logic [1:0] clk_en;
    logic [31:0] reload_ff [2];
    logic [31:0] value_ff [2];
    logic [7:0] ctrl_ff [2];
    logic [1:0] raw_ff;
    logic [1:0] nxt_raw;
    logic [1:0] nxt_masked;

    // Per-counter enables, already in the clock domain
    assign clk_en = {counter2_clock_enable, counter1_clock_enable};

    // One slice per counter
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
            logic [31:0] nxt_reload;
            logic [31:0] pend_val_ff;
            logic [31:0] nxt_pend_val;
            logic pend_ff;
            logic nxt_pend;
            logic [31:0] nxt_value;
            logic [7:0] nxt_ctrl;
            logic [7:0] pre_cnt_ff;
            logic [7:0] nxt_pre_cnt;
            logic hit;
            logic tick;
            logic [31:0] mask;
            logic [31:0] cur;
            logic set_irq;
            logic clr_irq;

            // Write decode and width mask for this counter
            assign hit = wr_ff && (addr_ff[11:6] == 6'h00) && (addr_ff[`DT_CH_STRIDE_BIT] == 1'(gi));
            assign clr_irq = hit && (addr_ff[4:2] == `DT_OFS_IRQ_CLEAR);
            assign mask = ctrl_ff[gi][`DT_CTRL_SIZE32] ? `DT_MASK32 : `DT_MASK16;
            assign cur = value_ff[gi] & mask;

            // Prescaled tick, only on edges with the clock enable high
            always_comb begin
                case (ctrl_ff[gi][`DT_CTRL_PRE_HI:`DT_CTRL_PRE_LO])
                    `DT_PRE_DIV1: tick = clk_en[gi];
                    `DT_PRE_DIV16: tick = clk_en[gi] && (pre_cnt_ff[3:0] == 4'hF);
                    `DT_PRE_DIV256: tick = clk_en[gi] && (pre_cnt_ff == 8'hFF);
                    default: tick = 1'b0;
                endcase
            end

            // Register writes, load pending and count
            always_comb begin
                nxt_reload = reload_ff[gi];
                nxt_pend_val = pend_val_ff;
                nxt_pend = pend_ff;
                nxt_ctrl = ctrl_ff[gi];
                nxt_value = value_ff[gi];
                nxt_pre_cnt = pre_cnt_ff;
                set_irq = 1'b0;
                if (clk_en[gi]) begin
                    nxt_pre_cnt = pre_cnt_ff + 8'h01;
                end
                if (pend_ff && clk_en[gi]) begin
                    nxt_value = pend_val_ff;
                    nxt_pend = 1'b0;
                end else if (ctrl_ff[gi][`DT_CTRL_ENABLE] && tick) begin
                    if (cur == 32'h00000000) begin
                        if (!ctrl_ff[gi][`DT_CTRL_ONESHOT]) begin
                            nxt_value = ctrl_ff[gi][`DT_CTRL_PERIODIC] ? reload_ff[gi] : mask;
                        end
                    end else begin
                        nxt_value = cur - 32'h00000001;
                        set_irq = (cur == 32'h00000001);
                    end
                end
                if (hit) begin
                    case (addr_ff[4:2])
                        `DT_OFS_RELOAD: begin
                            nxt_reload = hwdata;
                            nxt_pend_val = hwdata;
                            nxt_pend = 1'b1;
                        end
                        `DT_OFS_BG_RELOAD: begin
                            nxt_reload = hwdata;
                        end
                        `DT_OFS_CONTROL: begin
                            nxt_ctrl = hwdata[7:0] & `DT_CTRL_WR_MASK;
                        end
                        default: begin
                            nxt_reload = nxt_reload;
                        end
                    endcase
                end
                nxt_raw[gi] = set_irq || (raw_ff[gi] && !clr_irq);
                nxt_masked[gi] = test_mode_ff ? test_out_ff[gi] : (nxt_raw[gi] && nxt_ctrl[`DT_CTRL_IRQ_EN]);
            end

            // Counter state
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    reload_ff[gi] <= `DT_RELOAD_RESET;
                    pend_val_ff <= `DT_RELOAD_RESET;
                    pend_ff <= 1'b0;
                    value_ff[gi] <= `DT_VALUE_RESET;
                    ctrl_ff[gi] <= `DT_CTRL_RESET;
                    pre_cnt_ff <= 8'h00;
                    raw_ff[gi] <= 1'b0;
                end else begin
                    reload_ff[gi] <= nxt_reload;
                    pend_val_ff <= nxt_pend_val;
                    pend_ff <= nxt_pend;
                    value_ff[gi] <= nxt_value;
                    ctrl_ff[gi] <= nxt_ctrl;
                    pre_cnt_ff <= nxt_pre_cnt;
                    raw_ff[gi] <= nxt_raw[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Unmapped addresses and write-only registers read zero
    always_comb begin
        logic sel;
        sel = addr_ff[`DT_CH_STRIDE_BIT];
        rd_mux = 32'h00000000;
        if (addr_ff[11:6] == 6'h00) begin
            case (addr_ff[4:2])
                `DT_OFS_RELOAD: rd_mux = reload_ff[sel];
                `DT_OFS_BG_RELOAD: rd_mux = reload_ff[sel];
                `DT_OFS_VALUE: rd_mux = value_ff[sel];
                `DT_OFS_CONTROL: rd_mux = {24'h000000, ctrl_ff[sel]};
                `DT_OFS_RAW_STATUS: rd_mux = {31'h00000000, raw_ff[sel]};
                `DT_OFS_MASKED_STATUS: rd_mux = {31'h00000000, raw_ff[sel] && ctrl_ff[sel][`DT_CTRL_IRQ_EN]};
                default: rd_mux = 32'h00000000;
            endcase
        end else if (addr_ff == `DT_ADDR_TEST_CONTROL) begin
            rd_mux = {31'h00000000, test_mode_ff};
        end else if (addr_ff == `DT_ADDR_PERIPH_ID3) begin
            rd_mux = {24'h000000, rev_ff, 4'h0};
        end
    end

    // ------------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------------
    logic [1:0] irq_ff;
    logic irqc_ff;
    logic nxt_irqc;

    // Combined state: OR of both counters, or of the test bits
    always_comb begin
        nxt_irqc = |nxt_masked;
    end

    // Outputs track masked state, or test bits in test mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 2'b00;
            irqc_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_masked;
            irqc_ff <= nxt_irqc;
        end
    end

    // Pins straight from the output flip-flops
    assign counter1_irq_out = irq_ff[0];
    assign counter2_irq_out = irq_ff[1];
    assign combined_irq_out = irqc_ff;

endmodule // dt_timer

// [dt_timer_monitor.sv]
// Purpose: Port-level checks of the dual timer
// Assumes: hready is tied to hreadyout
// Notes: Bound to every dt_timer instance
`timescale 1ns/1ps

module dt_timer_monitor (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic hsel, // Select
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Direction
    input wire logic hready, // Bus ready
    input wire logic [31:0] hrdata, // Read data
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic counter1_clock_enable, // Counter 1 enable
    input wire logic counter2_clock_enable, // Counter 2 enable
    input wire logic counter1_irq_out, // Counter 1 interrupt
    input wire logic counter2_irq_out, // Counter 2 interrupt
    input wire logic combined_irq_out // Combined interrupt
);
    // ------------------------------------------------------------
    // Write data phase tracker
    // ------------------------------------------------------------
    logic wr_dp_ff;
    logic nxt_wr_dp;

    // Next value: a write address phase taken now
    always_comb begin
        nxt_wr_dp = hsel & htrans[1] & hready & hwrite;
    end

    // Register the tracker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp_ff <= 1'b0;
        end else begin
            wr_dp_ff <= nxt_wr_dp;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_rd_take;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_wr_take;
        hsel && htrans[1] && hready && hwrite;
    endsequence
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    property p_comb;
        combined_irq_out == (counter1_irq_out | counter2_irq_out);
    endproperty
    property p_rise1;
        $rose(counter1_irq_out) |-> $past(counter1_clock_enable) || $past(counter1_clock_enable, 2)
            || $past(wr_dp_ff) || $past(wr_dp_ff, 2);
    endproperty
    property p_rise2;
        $rose(counter2_irq_out) |-> $past(counter2_clock_enable) || $past(counter2_clock_enable, 2)
            || $past(wr_dp_ff) || $past(wr_dp_ff, 2);
    endproperty
    property p_fall1;
        $fell(counter1_irq_out) |-> $past(wr_dp_ff) || $past(wr_dp_ff, 2);
    endproperty
    property p_fall2;
        $fell(counter2_irq_out) |-> $past(wr_dp_ff) || $past(wr_dp_ff, 2);
    endproperty
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_rd_wait;
        s_rd_take |=> s_rd_wait;
    endproperty
    property p_wr_ready;
        s_wr_take |=> hreadyout;
    endproperty
    property p_rdata_hold;
        $changed(hrdata) |-> $rose(hreadyout);
    endproperty

    a_comb: assert property (p_comb)
        else $error("combined interrupt is not the OR of both");
    a_rise1: assert property (p_rise1)
        else $error("counter 1 interrupt rose without enable or write");
    a_rise2: assert property (p_rise2)
        else $error("counter 2 interrupt rose without enable or write");
    a_fall1: assert property (p_fall1)
        else $error("counter 1 interrupt fell without a write");
    a_fall2: assert property (p_fall2)
        else $error("counter 2 interrupt fell without a write");
    a_okay: assert property (p_okay)
        else $error("response not OKAY");
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait state wrong");
    a_wr_ready: assert property (p_wr_ready)
        else $error("write data phase stalled");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed outside a read");
endmodule // dt_timer_monitor

bind dt_timer dt_timer_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .counter1_clock_enable(counter1_clock_enable), .counter2_clock_enable(counter2_clock_enable),
    .counter1_irq_out(counter1_irq_out), .counter2_irq_out(counter2_irq_out),
    .combined_irq_out(combined_irq_out));

// [tb.sv]
// Purpose: Self-checking bench for the dual timer
// Assumes: 200 MHz clock, bus master model drives the bus
// Notes: Counter clock enables and revision come from here
`timescale 1ns/1ps

module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic counter1_clock_enable = 1'b0;
    logic counter2_clock_enable = 1'b0;
    logic [3:0] revision_tieoff_in = 4'hA;
    logic counter1_irq_out, counter2_irq_out, combined_irq_out;
    int err_count = 0;
    int n_tests = 0;

    // ------------------------------------------------------------
    // Clock, design and bus master
    // ------------------------------------------------------------
    always #2.5 hclk = ~hclk;

    dt_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .counter1_clock_enable(counter1_clock_enable),
        .counter2_clock_enable(counter2_clock_enable), .revision_tieoff_in(revision_tieoff_in),
        .counter1_irq_out(counter1_irq_out), .counter2_irq_out(counter2_irq_out),
        .combined_irq_out(combined_irq_out));

    dt_bus_master bm_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bm_u.xfer(1'b1, a, d, rd);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        bm_u.xfer(1'b0, a, 32'h0, rd);
        chk(rd, exp);
    endtask

    // Interrupt pins as {combined, counter 2, counter 1}
    task automatic pins(input logic [2:0] exp);
        repeat (2) @(posedge hclk);
        #1;
        chk({29'h0, combined_irq_out, counter2_irq_out, counter1_irq_out}, {29'h0, exp});
    endtask

    // One enabled edge for counter 1
    task automatic tick1();
        counter1_clock_enable <= 1'b1;
        @(posedge hclk);
        counter1_clock_enable <= 1'b0;
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        logic [31:0] k;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rc(12'h008, 32'h00000020);
        rc(12'h010, 32'h00000000);
        rc(12'hFEC, 32'h000000A0);
        rc(12'h800, 32'h00000000);
        wr(12'h028, 32'h00000082);
        wr(12'h000, 32'h00000003);
        wr(12'h008, 32'h000000E2);
        rc(12'h004, 32'hFFFFFFFF);
        counter1_clock_enable <= 1'b1;
        for (n = 0; n < 20 && counter1_irq_out !== 1'b1; n++) @(posedge hclk);
        counter1_clock_enable <= 1'b0;
        pins(3'b101);
        rc(12'h014, 32'h00000001);
        rc(12'h024, 32'hFFFFFFFF);
        wr(12'h008, 32'h000000C2);
        rc(12'h010, 32'h00000001);
        rc(12'h014, 32'h00000000);
        pins(3'b000);
        wr(12'h008, 32'h000000E2);
        wr(12'h00C, 32'h1234ABCD);
        rc(12'h010, 32'h00000000);
        pins(3'b000);
        wr(12'h000, 32'h00000009);
        tick1();
        wr(12'h018, 32'h00000010);
        rc(12'h004, 32'h00000009);
        rc(12'h000, 32'h00000010);
        wr(12'h000, 32'h00000007);
        wr(12'h018, 32'h00000002);
        rc(12'h000, 32'h00000002);
        tick1();
        rc(12'h004, 32'h00000007);
        counter1_clock_enable <= 1'b1;
        repeat (8) @(posedge hclk);
        counter1_clock_enable <= 1'b0;
        rc(12'h004, 32'h00000002);
        wr(12'h00C, 32'h00000000);
        wr(12'hF00, 32'hFFFFFFFF);
        rc(12'hF00, 32'h00000001);
        for (k = 32'h0; k < 32'h4; k++) begin
            wr(12'hF04, k);
            pins({k[1] | k[0], k[1], k[0]});
        end
        wr(12'hF00, 32'h00000000);
        pins(3'b000);
        wr(12'h020, 32'h00000002);
        wr(12'h028, 32'h000000E6);
        counter2_clock_enable <= 1'b1;
        for (n = 0; n < 100 && counter2_irq_out !== 1'b1; n++) @(posedge hclk);
        counter2_clock_enable <= 1'b0;
        chk({31'h0, n >= 16 && n <= 40}, 32'h00000001);
        test_done();
    end

    // Watchdog against a hung handshake
    initial begin
        #50000;
        err_count++;
        test_done();
    end
endmodule // tb
